// >>> logic/mfrc_pkg.sv
// constants, tables and types of the motor fault response block
package mfrc_pkg;
    // register word indexes; byte address is four times the index
    localparam logic [9:0] MFRC_IDX_SETUP_ONE = 10'h092;
    localparam logic [9:0] MFRC_IDX_SETUP_TWO = 10'h094;
    localparam logic [9:0] MFRC_IDX_STATUS = 10'h0C0;
    localparam logic [9:0] MFRC_IDX_CLEAR = 10'h0C1;
    localparam logic [31:0] MFRC_SETUP_ONE_RST = 32'h00000000;
    localparam logic [31:0] MFRC_SETUP_TWO_RST = 32'h00000000;
    localparam logic [31:0] MFRC_ZERO_WORD = 32'h00000000;

    // fault_setup_one field positions
    localparam int MFRC_NOMTR_DEG_LSB = 28;
    localparam int MFRC_CBC_MODE_LSB = 24;
    localparam int MFRC_LOCK_THR_LSB = 19;
    localparam int MFRC_LOCK_MODE_LSB = 15;
    localparam int MFRC_LOCK_DEG_LSB = 11;
    localparam int MFRC_CBC_RETRY_LSB = 8;
    localparam int MFRC_MTR_MODE_LSB = 3;
    localparam int MFRC_STALL_RECOVERY_WAIT_LSB = 0;
    // fault_setup_two field positions
    localparam int MFRC_ABN_EN_BIT = 30;
    localparam int MFRC_DESYNC_EN_BIT = 29;
    localparam int MFRC_NOMTR_EN_BIT = 28;
    localparam int MFRC_ABN_THR_LSB = 24;
    localparam int MFRC_SYNC_TIMES_LSB = 21;
    localparam int MFRC_NOMTR_THR_LSB = 18;
    localparam int MFRC_OV_MODE_BIT = 17;
    localparam int MFRC_VM_MAX_LSB = 14;
    localparam int MFRC_RETRY_TIMES_LSB = 7;
    // status and clear layout
    localparam int MFRC_STAT_LIVE_LSB = 16;
    localparam int MFRC_STAT_USED_LSB = 24;
    localparam int MFRC_CLR_LOCK_BIT = 16;
    localparam int MFRC_CLR_OV_BIT = 17;
    localparam int MFRC_EV_CBC = 0;
    localparam int MFRC_EV_CBC_REPORT = 1;
    localparam int MFRC_EV_LOCK_CUR = 2;
    localparam int MFRC_EV_ABN = 3;
    localparam int MFRC_EV_DESYNC = 4;
    localparam int MFRC_EV_NOMTR = 5;
    localparam int MFRC_EV_LOCK_REPORT = 6;
    localparam int MFRC_EV_OV = 7;

    // response codes
    localparam logic [3:0] MFRC_CBC_CUR_LOW = 4'h2;
    localparam logic [3:0] MFRC_CBC_PERIODS = 4'h4;
    localparam logic [3:0] MFRC_CBC_REPORT = 4'h6;
    localparam logic [3:0] MFRC_LOCK_AUTO = 4'h4;
    localparam logic [3:0] MFRC_LOCK_REPORT = 4'h8;
    localparam logic [4:0] MFRC_LOCK_THR_MAX = 5'h1B;
    localparam logic [3:0] MFRC_SYNC_BASE = 4'h2;

    // amplifier level in 0.5 mV units, supply in 0.1 V units, speed in Hz
    localparam logic [15:0] MFRC_LOCK_STEP = 16'h00C8;
    localparam logic [15:0] MFRC_SPEED_STEP = 16'h00FA;
    localparam logic [15:0] MFRC_NOMTR_DEG_MS [8] = '{16'h0001, 16'h000A, 16'h0019,
        16'h0032, 16'h0064, 16'h00FA, 16'h01F4, 16'h03E8};
    localparam logic [15:0] MFRC_LOCK_DEG_MS [16] = '{16'h0001, 16'h0002, 16'h0005,
        16'h000A, 16'h0019, 16'h0032, 16'h004B, 16'h0064, 16'h00FA, 16'h01F4,
        16'h03E8, 16'h09C4, 16'h1388, 16'h2710, 16'h61A8, 16'hC350};
    localparam logic [15:0] MFRC_RETRY_MS [8] = '{16'h0064, 16'h01F4, 16'h03E8,
        16'h07D0, 16'h0BB8, 16'h1388, 16'h1D4C, 16'h2710};
    localparam logic [15:0] MFRC_NOMTR_LEVEL [8] = '{16'h000A, 16'h000F, 16'h0014,
        16'h0019, 16'h0028, 16'h0032, 16'h003C, 16'h0050};
    localparam logic [15:0] MFRC_VM_LIMIT [8] = '{16'h0000, 16'h0064, 16'h0096,
        16'h00DC, 16'h0140, 16'h0190, 16'h01F4, 16'h0258};
    localparam logic [4:0] MFRC_RETRY_LIMIT [8] = '{5'h00, 5'h02, 5'h03, 5'h05,
        5'h07, 5'h0A, 5'h0F, 5'h14};

    // one millisecond at a 10 ns clock
    localparam int MFRC_MS_NS = 1000000;
    localparam int MFRC_CLK_NS = 10;
    localparam int MFRC_MS_CYCLES = MFRC_MS_NS / MFRC_CLK_NS;

    typedef enum logic [2:0] {
        MFRC_DRIVE, MFRC_TRISTATE, MFRC_RECIRC, MFRC_HS_BRAKE, MFRC_LS_BRAKE
    } mfrc_bridge_t;
    typedef enum logic [1:0] {LK_IDLE, LK_LATCHED, LK_RETRY} mfrc_lock_state_t;
endpackage

// >>> logic/mfrc_timer_if.sv
// request and answer of one qualification timer
`timescale 1ns/100ps
interface mfrc_timer_if;
    logic cond;
    logic tick;
    logic [15:0] limit;
    logic done;
    modport ctrl(output cond, output tick, output limit, input done);
    modport timer(input cond, input tick, input limit, output done);
endinterface

// >>> logic/mfrc_deglitch.sv
// millisecond qualification timer, restarts whenever its condition drops
`timescale 1ns/100ps
module mfrc_deglitch (
    input wire logic clk_i,
    input wire logic rst_i,
    mfrc_timer_if.timer tif
);
    logic [15:0] cnt_reg;
    logic [15:0] cnt_next;
    wire at_limit = (cnt_reg >= tif.limit);

    // saturating count so a long hold cannot wrap and lose the result
    assign cnt_next = !tif.cond ? 16'h0000 :
                      (tif.tick && !at_limit) ? cnt_reg + 16'h0001 : cnt_reg;
    assign tif.done = tif.cond && at_limit;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_reg <= 16'h0000;
        end else begin
            cnt_reg <= cnt_next;
        end
    end
endmodule

// >>> logic/mfrc_top.sv
// fault response unit: current limit, lock, no-motor and overvoltage handling
//
// Local design decision: register access over Wishbone.
`timescale 1ns/100ps
module mfrc_top #(
    parameter int unsigned MS_CYCLES = mfrc_pkg::MFRC_MS_CYCLES
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [11:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic cbc_over_i,
    input wire logic pwm_period_i,
    input wire logic high_side_mod_i,
    input wire logic [15:0] amp_level_i,
    input wire logic [15:0] speed_hz_i,
    input wire logic desync_pulse_i,
    input wire logic [15:0] supply_level_i,
    output mfrc_pkg::mfrc_bridge_t bridge_mode_o,
    output logic fault_pin_low_active_n_o
);
    import mfrc_pkg::*;

    function automatic logic [31:0] merge_lanes(input logic [31:0] old_w,
                                                input logic [31:0] new_w,
                                                input logic [3:0] sel);
        logic [31:0] res;
        res = old_w;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                res[i*8 +: 8] = new_w[i*8 +: 8];
            end
        end
        return res;
    endfunction

    function automatic mfrc_bridge_t code_bridge(input logic [3:0] code);
        case (code[1:0])
            2'h0: code_bridge = MFRC_TRISTATE;
            2'h1: code_bridge = MFRC_RECIRC;
            2'h2: code_bridge = MFRC_HS_BRAKE;
            default: code_bridge = MFRC_LS_BRAKE;
        endcase
    endfunction

    // ---------------- register bus ----------------
    logic [31:0] setup_one_reg;
    logic [31:0] setup_two_reg;
    logic [31:0] dat_reg;
    logic ack_reg;
    logic [7:0] sticky_reg;
    logic [7:0] sticky_next;

    wire bus_req = wb_cyc_i && wb_stb_i;
    wire [9:0] bus_idx = wb_adr_i[11:2];
    wire hit_one = (bus_idx == MFRC_IDX_SETUP_ONE);
    wire hit_two = (bus_idx == MFRC_IDX_SETUP_TWO);
    wire hit_stat = (bus_idx == MFRC_IDX_STATUS);
    wire hit_clr = (bus_idx == MFRC_IDX_CLEAR);
    // writes land at the edge that samples ack, as the classic cycle ends
    wire wr_commit = bus_req && ack_reg && wb_we_i;
    wire [31:0] clr_word = merge_lanes(MFRC_ZERO_WORD, wb_dat_i, wb_sel_i);
    wire clr_wr = wr_commit && hit_clr;
    wire clr_lock = clr_wr && clr_word[MFRC_CLR_LOCK_BIT];
    wire clr_ov = clr_wr && clr_word[MFRC_CLR_OV_BIT];

    // ---------------- field decode ----------------
    wire [2:0] nomtr_deg = setup_one_reg[MFRC_NOMTR_DEG_LSB +: 3];
    wire [3:0] cbc_mode = setup_one_reg[MFRC_CBC_MODE_LSB +: 4];
    wire [4:0] lock_thr = setup_one_reg[MFRC_LOCK_THR_LSB +: 5];
    wire [3:0] lock_mode = setup_one_reg[MFRC_LOCK_MODE_LSB +: 4];
    wire [3:0] lock_deg = setup_one_reg[MFRC_LOCK_DEG_LSB +: 4];
    wire [2:0] cbc_retry = setup_one_reg[MFRC_CBC_RETRY_LSB +: 3];
    wire [3:0] mtr_mode = setup_one_reg[MFRC_MTR_MODE_LSB +: 4];
    wire [2:0] stall_recovery_wait = setup_one_reg[MFRC_STALL_RECOVERY_WAIT_LSB +: 3];
    wire abn_en = setup_two_reg[MFRC_ABN_EN_BIT];
    wire desync_en = setup_two_reg[MFRC_DESYNC_EN_BIT];
    wire nomtr_en = setup_two_reg[MFRC_NOMTR_EN_BIT];
    wire [3:0] abn_thr = setup_two_reg[MFRC_ABN_THR_LSB +: 4];
    wire [2:0] sync_times = setup_two_reg[MFRC_SYNC_TIMES_LSB +: 3];
    wire [2:0] nomtr_thr = setup_two_reg[MFRC_NOMTR_THR_LSB +: 3];
    wire ov_auto = setup_two_reg[MFRC_OV_MODE_BIT];
    wire [2:0] vm_max = setup_two_reg[MFRC_VM_MAX_LSB +: 3];
    wire [2:0] retry_times = setup_two_reg[MFRC_RETRY_TIMES_LSB +: 3];

    // ---------------- millisecond tick ----------------
    logic [31:0] ms_cnt_reg;
    wire ms_last = (ms_cnt_reg == 32'(MS_CYCLES - 1));

    // ---------------- cycle-by-cycle current limit ----------------
    logic cbc_active_reg;
    logic [2:0] cbc_wait_reg;
    logic [3:0] cbc_code_reg;
    // codes 2/3 need high-side modulation; otherwise they act as disabled
    wire cbc_en = (cbc_mode < MFRC_CBC_REPORT) &&
                  ((cbc_mode != MFRC_CBC_CUR_LOW && cbc_mode != (MFRC_CBC_CUR_LOW + 4'h1))
                   || high_side_mod_i);
    wire cbc_report_hit = (cbc_mode == MFRC_CBC_REPORT) && cbc_over_i;
    wire cbc_start = !cbc_active_reg && cbc_en && cbc_over_i;
    wire cbc_sel_low = (cbc_code_reg >= MFRC_CBC_CUR_LOW) && (cbc_code_reg < MFRC_CBC_PERIODS);
    wire cbc_sel_per = (cbc_code_reg >= MFRC_CBC_PERIODS);
    wire cbc_end = cbc_active_reg && (
        (!cbc_sel_low && !cbc_sel_per && pwm_period_i) ||
        (cbc_sel_low && !cbc_over_i) ||
        (cbc_sel_per && pwm_period_i && cbc_wait_reg == cbc_retry));
    wire cbc_flags_pin = cbc_active_reg && !cbc_code_reg[0];

    // ---------------- detectors ----------------
    wire [15:0] lock_level = 16'(lock_thr) * MFRC_LOCK_STEP;
    wire lock_cur_cond = (lock_mode <= MFRC_LOCK_REPORT) && (lock_thr <= MFRC_LOCK_THR_MAX) &&
                         (amp_level_i >= lock_level);
    wire [15:0] abn_level = (16'(abn_thr) + 16'h0001) * MFRC_SPEED_STEP;
    wire abn_hit = abn_en && (speed_hz_i > abn_level);
    wire nomtr_cond = nomtr_en && (amp_level_i < MFRC_NOMTR_LEVEL[nomtr_thr]);
    logic [3:0] desync_cnt_reg;
    wire [3:0] desync_need = 4'(sync_times) + MFRC_SYNC_BASE;
    wire desync_trip = desync_en && desync_pulse_i &&
                       (desync_cnt_reg + 4'h1 >= desync_need);

    mfrc_timer_if nomtr_tif();
    mfrc_timer_if lockc_tif();
    mfrc_timer_if retry_tif();

    assign nomtr_tif.cond = nomtr_cond;
    assign nomtr_tif.tick = ms_last;
    assign nomtr_tif.limit = MFRC_NOMTR_DEG_MS[nomtr_deg];
    assign lockc_tif.cond = lock_cur_cond;
    assign lockc_tif.tick = ms_last;
    assign lockc_tif.limit = MFRC_LOCK_DEG_MS[lock_deg];

    mfrc_deglitch u_nomtr_deg (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .tif(nomtr_tif)
    );
    mfrc_deglitch u_lockc_deg (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .tif(lockc_tif)
    );
    mfrc_deglitch u_retry_wait (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .tif(retry_tif)
    );

    wire nomtr_hit = nomtr_tif.done;
    wire lockc_hit = lockc_tif.done;
    wire motor_hit = abn_hit || desync_trip || nomtr_hit;
    wire mtr_active = (mtr_mode < MFRC_LOCK_REPORT);
    wire lock_active = (lock_mode < MFRC_LOCK_REPORT);
    wire lock_report = ((lock_mode == MFRC_LOCK_REPORT) && lockc_hit) ||
                       ((mtr_mode == MFRC_LOCK_REPORT) && motor_hit);
    // current lock takes priority when both detectors fire together
    wire lock_trig = (lock_active && lockc_hit) || (mtr_active && motor_hit);
    wire [3:0] trig_code = (lock_active && lockc_hit) ? lock_mode : mtr_mode;

    // ---------------- lock response state machine ----------------
    mfrc_lock_state_t lock_state_reg;
    mfrc_lock_state_t lock_state_next;
    logic [3:0] lock_code_reg;
    logic [4:0] retry_used_reg;
    logic [4:0] retry_used_next;
    wire [4:0] retry_cap = MFRC_RETRY_LIMIT[retry_times];
    wire retries_spent = (retry_cap != 5'h00) && (retry_used_reg >= retry_cap);

    assign retry_tif.cond = (lock_state_reg == LK_RETRY);
    assign retry_tif.tick = ms_last;
    assign retry_tif.limit = MFRC_RETRY_MS[stall_recovery_wait];

    always_comb begin
        lock_state_next = lock_state_reg;
        retry_used_next = retry_used_reg;
        case (lock_state_reg)
            LK_IDLE: begin
                if (lock_trig) begin
                    if (trig_code < MFRC_LOCK_AUTO || retries_spent) begin
                        lock_state_next = LK_LATCHED;
                    end else begin
                        lock_state_next = LK_RETRY;
                    end
                end
            end
            LK_RETRY: begin
                if (retry_tif.done) begin
                    lock_state_next = LK_IDLE;
                    retry_used_next = retry_used_reg + 5'h01;
                end
            end
            LK_LATCHED: begin
                if (clr_lock) begin
                    lock_state_next = LK_IDLE;
                    retry_used_next = 5'h00;
                end
            end
            default: begin
                lock_state_next = LK_IDLE;
            end
        endcase
    end

    // ---------------- overvoltage ----------------
    logic ov_fault_reg;
    wire ov_cond = (vm_max != 3'h0) && (supply_level_i > MFRC_VM_LIMIT[vm_max]);
    // a persisting condition wins over a clear, so the fault cannot be dropped early
    wire ov_next = ov_cond || (ov_fault_reg && !(ov_auto || clr_ov));

    // ---------------- gate drive and fault pin ----------------
    mfrc_bridge_t bridge_next;
    wire lock_holds = (lock_state_reg != LK_IDLE);
    assign bridge_next = ov_fault_reg ? MFRC_TRISTATE :
                         lock_holds ? code_bridge(lock_code_reg) :
                         cbc_active_reg ? MFRC_RECIRC : MFRC_DRIVE;
    wire pin_next = !((lock_state_reg == LK_LATCHED) || cbc_flags_pin || ov_fault_reg);

    // ---------------- status events ----------------
    logic [7:0] events;
    always_comb begin
        events = 8'h00;
        events[MFRC_EV_CBC] = cbc_start;
        events[MFRC_EV_CBC_REPORT] = cbc_report_hit;
        events[MFRC_EV_LOCK_CUR] = lockc_hit;
        events[MFRC_EV_ABN] = abn_hit;
        events[MFRC_EV_DESYNC] = desync_trip;
        events[MFRC_EV_NOMTR] = nomtr_hit;
        events[MFRC_EV_LOCK_REPORT] = lock_report;
        events[MFRC_EV_OV] = ov_cond;
    end
    // set wins over a clear in the same cycle
    assign sticky_next = (sticky_reg & ~(clr_wr ? clr_word[7:0] : 8'h00)) | events;

    wire [31:0] status_word = {3'h0, retry_used_reg, 4'h0, ov_fault_reg,
                               (lock_state_reg == LK_RETRY),
                               (lock_state_reg == LK_LATCHED), cbc_active_reg,
                               8'h00, sticky_reg};
    wire [31:0] read_word = hit_one ? setup_one_reg :
                            hit_two ? setup_two_reg :
                            hit_stat ? status_word : MFRC_ZERO_WORD;

    // ---------------- registers ----------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg <= 1'b0;
            dat_reg <= MFRC_ZERO_WORD;
            setup_one_reg <= MFRC_SETUP_ONE_RST;
            setup_two_reg <= MFRC_SETUP_TWO_RST;
        end else begin
            ack_reg <= bus_req && !ack_reg;
            if (bus_req && !ack_reg) begin
                dat_reg <= wb_we_i ? MFRC_ZERO_WORD : read_word;
            end
            if (wr_commit && hit_one) begin
                setup_one_reg <= merge_lanes(setup_one_reg, wb_dat_i, wb_sel_i);
            end
            if (wr_commit && hit_two) begin
                setup_two_reg <= merge_lanes(setup_two_reg, wb_dat_i, wb_sel_i);
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ms_cnt_reg <= 32'h00000000;
        end else begin
            ms_cnt_reg <= ms_last ? 32'h00000000 : ms_cnt_reg + 32'h00000001;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cbc_active_reg <= 1'b0;
            cbc_wait_reg <= 3'h0;
            cbc_code_reg <= 4'h0;
        end else if (cbc_start) begin
            cbc_active_reg <= 1'b1;
            cbc_wait_reg <= 3'h0;
            cbc_code_reg <= cbc_mode;
        end else if (cbc_end) begin
            cbc_active_reg <= 1'b0;
        end else if (cbc_active_reg && pwm_period_i) begin
            cbc_wait_reg <= cbc_wait_reg + 3'h1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            desync_cnt_reg <= 4'h0;
        end else if (!desync_en || desync_trip) begin
            desync_cnt_reg <= 4'h0;
        end else if (desync_pulse_i) begin
            desync_cnt_reg <= desync_cnt_reg + 4'h1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            lock_state_reg <= LK_IDLE;
            lock_code_reg <= 4'h0;
            retry_used_reg <= 5'h00;
        end else begin
            lock_state_reg <= lock_state_next;
            retry_used_reg <= retry_used_next;
            if (lock_state_reg == LK_IDLE && lock_trig) begin
                lock_code_reg <= trig_code;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ov_fault_reg <= 1'b0;
            sticky_reg <= 8'h00;
            bridge_mode_o <= MFRC_DRIVE;
            fault_pin_low_active_n_o <= 1'b1;
        end else begin
            ov_fault_reg <= ov_next;
            sticky_reg <= sticky_next;
            bridge_mode_o <= bridge_next;
            fault_pin_low_active_n_o <= pin_next;
        end
    end

    assign wb_ack_o = ack_reg;
    assign wb_dat_o = dat_reg;
endmodule

// >>> dv/mfrc_bridge_model.sv
// half-bridge and shunt stand-in: period pulses, current only while driven
`timescale 1ns/100ps
module mfrc_bridge_model
    import mfrc_pkg::*;
#(parameter int PERIOD = 16) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic push_i,
    input wire mfrc_pkg::mfrc_bridge_t bridge_mode_i,
    output logic pwm_period_o,
    output logic cbc_over_o
);
    logic [7:0] cnt_reg;
    // current collapses as soon as the bridge stops driving
    assign cbc_over_o = push_i && bridge_mode_i == MFRC_DRIVE;
    assign pwm_period_o = cnt_reg == 8'h00;
    always_ff @(posedge clk_i) begin
        if (rst_i || cnt_reg == 8'(PERIOD - 1)) cnt_reg <= 8'h00;
        else cnt_reg <= cnt_reg + 8'h01;
    end
endmodule

// >>> dv/mfrc_chk.sv
// port assertions for the fault response unit
`timescale 1ns/100ps
module mfrc_chk
    import mfrc_pkg::*;
#(parameter int unsigned MS_CYCLES = MFRC_MS_CYCLES) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [11:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic cbc_over_i,
    input wire logic pwm_period_i,
    input wire logic high_side_mod_i,
    input wire logic [15:0] amp_level_i,
    input wire logic [15:0] speed_hz_i,
    input wire logic desync_pulse_i,
    input wire logic [15:0] supply_level_i,
    input wire mfrc_pkg::mfrc_bridge_t bridge_mode_o,
    input wire logic fault_pin_low_active_n_o
);
    logic [31:0] sh1_reg;
    logic [31:0] sh2_reg;
    wire req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire hit1 = wb_adr_i == {MFRC_IDX_SETUP_ONE, 2'b00};
    wire hit2 = wb_adr_i == {MFRC_IDX_SETUP_TWO, 2'b00};
    wire [3:0] cbc_code = sh1_reg[27:24];
    // only judge the current limit when no other fault source can interfere
    wire quiet = sh1_reg[18:15] > 4'h8 && sh1_reg[6:3] > 4'h8 && sh2_reg[30:28] == 3'h0
        && sh2_reg[16:14] == 3'h0;
    wire free = quiet && fault_pin_low_active_n_o && bridge_mode_o == MFRC_DRIVE;
    wire acts = cbc_code < 4'h6 && (high_side_mod_i || cbc_code[3:1] != 3'h1);
    wire [15:0] vm_lim = MFRC_VM_LIMIT[sh2_reg[16:14]];
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sh1_reg <= MFRC_SETUP_ONE_RST;
            sh2_reg <= MFRC_SETUP_TWO_RST;
        end else if (wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o) begin
            for (int i = 0; i < 4; i++) begin
                if (wb_sel_i[i] && hit1) sh1_reg[8*i +: 8] <= wb_dat_i[8*i +: 8];
                if (wb_sel_i[i] && hit2) sh2_reg[8*i +: 8] <= wb_dat_i[8*i +: 8];
            end
        end
    end
    a_ack_single: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_ack_o |=> !wb_ack_o) else $error("ack held too long");
    a_ack_answer: assert property (@(posedge clk_i) disable iff (rst_i)
        req |=> wb_ack_o) else $error("request not answered");
    a_write_zero: assert property (@(posedge clk_i) disable iff (rst_i)
        req && wb_we_i |=> wb_dat_o == MFRC_ZERO_WORD) else $error("write data not zero");
    a_reg_readback: assert property (@(posedge clk_i) disable iff (rst_i)
        req && !wb_we_i && (hit1 || hit2) |=> wb_dat_o == (hit1 ? sh1_reg : sh2_reg))
        else $error("setup readback wrong");
    a_cbc_recirc: assert property (@(posedge clk_i) disable iff (rst_i)
        free && cbc_over_i && acts && !pwm_period_i ##1 !pwm_period_i
        |=> bridge_mode_o == MFRC_RECIRC) else $error("limit did not recirculate");
    a_cbc_pin_low: assert property (@(posedge clk_i) disable iff (rst_i)
        free && cbc_over_i && acts && !cbc_code[0] && !pwm_period_i ##1 !pwm_period_i
        |=> !fault_pin_low_active_n_o) else $error("limit pin not pulled");
    a_cbc_off: assert property (@(posedge clk_i) disable iff (rst_i)
        free [*2] ##0 (cbc_over_i && cbc_code > 4'h5) |=> ##1
        (bridge_mode_o == MFRC_DRIVE && fault_pin_low_active_n_o)) else $error("limit acted");
    a_ov_trip: assert property (@(posedge clk_i) disable iff (rst_i)
        sh2_reg[16:14] != 3'h0 && supply_level_i > vm_lim |=> ##1
        (bridge_mode_o == MFRC_TRISTATE && !fault_pin_low_active_n_o)) else $error("no ov trip");
endmodule
bind mfrc_top mfrc_chk #(.MS_CYCLES(MS_CYCLES)) u_chk (.*);

// >>> dv/mfrc_top_bench.sv
// self-checking bench for the fault response unit
`timescale 1ns/100ps
module mfrc_top_bench;
    import mfrc_pkg::*;
    logic clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic push = 1'b0, high_side_mod_i = 1'b1, desync_pulse_i = 1'b0;
    logic [11:0] wb_adr_i = 12'h000;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rdv, v, seed = 32'h4;
    logic [3:0] wb_sel_i = 4'hF;
    logic [15:0] amp_level_i = 16'h0, speed_hz_i = 16'h0, supply_level_i = 16'h0;
    logic wb_ack_o, fault_pin_low_active_n_o, cbc_over_i, pwm_period_i;
    mfrc_bridge_t bridge_mode_o;
    int n_fail = 0, checks_done = 0;
    localparam mfrc_bridge_t LOCK_BR [5] = '{MFRC_TRISTATE, MFRC_RECIRC, MFRC_HS_BRAKE,
        MFRC_LS_BRAKE, MFRC_TRISTATE};
    always #5 clk_i = ~clk_i;
    mfrc_top #(.MS_CYCLES(10)) DUT (.*);
    mfrc_bridge_model u_model (.clk_i(clk_i), .rst_i(rst_i), .push_i(push),
        .bridge_mode_i(bridge_mode_o), .pwm_period_o(pwm_period_i), .cbc_over_o(cbc_over_i));
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic mfrc_bridge_t cbc_hold(input int c);
        return (c < 6) ? MFRC_RECIRC : MFRC_DRIVE;
    endfunction
    function automatic logic cbc_pin(input int c);
        return !(c < 6 && c % 2 == 0);
    endfunction
    task automatic cmp(input logic [31:0] g, input logic [31:0] e);
        checks_done++;
        if (g !== e) begin
            n_fail++;
            $display("BAD at %0t got %h expected %h", $time, g, e);
        end
    endtask
    task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1);
        cmp(n, 2);
        rdv = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
    endtask
    task automatic wfor(input mfrc_bridge_t e, input int lim);
        int n;
        n = 0;
        while (bridge_mode_o !== e && n < lim) begin
            @(posedge clk_i);
            #1;
            n++;
        end
        cmp(bridge_mode_o, e);
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    initial begin
        #300000;
        n_fail++;
        end_sim();
    end
    initial begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            // random setups keep detectors off so no slow retry is left running
            v = i[0] ? (xs() & 32'h8FFFFFFF) : ((xs() & 32'hFFF87FFF) | 32'h00048000);
            speed_hz_i <= v[15:0];
            if (i < 2) wb(1'b0, i[0] ? 12'h250 : 12'h248, 32'h0);
            if (i < 2) cmp(rdv, 32'h0);
            wb(1'b1, i[0] ? 12'h250 : 12'h248, v);
            wb(1'b0, i[0] ? 12'h250 : 12'h248, 32'h0);
            cmp(rdv, v);
        end
        wb(1'b1, 12'h250, 32'h0);
        wb(1'b1, 12'h304, 32'h000300FF);
        wb(1'b0, 12'h004, 32'h0);
        cmp(rdv, 32'h0);
        for (int c = 0; c < 8; c++) begin
            wb(1'b1, 12'h248, 32'h00048248 | (32'(c) << 24));
            do @(negedge clk_i); while (pwm_period_i !== 1'b1);
            @(posedge clk_i);
            push <= 1'b1;
            repeat (2) @(posedge clk_i);
            #1;
            cmp(bridge_mode_o, cbc_hold(c));
            cmp(fault_pin_low_active_n_o, cbc_pin(c));
            @(posedge clk_i);
            push <= 1'b0;
            do @(negedge clk_i); while (pwm_period_i !== 1'b1);
            repeat (3) @(posedge clk_i);
            #1;
            cmp(bridge_mode_o, (c == 4 || c == 5) ? MFRC_RECIRC : MFRC_DRIVE);
            repeat (40) @(posedge clk_i);
        end
        for (int m = 0; m < 5; m++) begin
            wb(1'b1, 12'h248, 32'h07081048 | (32'(m) << 15));
            amp_level_i <= 16'h00C8;
            repeat (30) @(posedge clk_i);
            amp_level_i <= 16'h00C7;
            repeat (60) @(posedge clk_i);
            #1;
            cmp(bridge_mode_o, MFRC_DRIVE);
            @(posedge clk_i);
            amp_level_i <= 16'h00C8;
            wfor(LOCK_BR[m], 70);
            cmp(fault_pin_low_active_n_o, m == 4);
            @(posedge clk_i);
            amp_level_i <= 16'h0000;
            repeat (900) @(posedge clk_i);
            #1;
            cmp(bridge_mode_o, LOCK_BR[m]);
            if (m < 4) wb(1'b1, 12'h304, 32'h00010000);
            wfor(MFRC_DRIVE, 1100);
        end
        speed_hz_i <= 16'h03E8;
        wb(1'b1, 12'h250, 32'h43000000);
        wb(1'b1, 12'h248, 32'h07048018);
        repeat (5) @(posedge clk_i);
        #1;
        cmp(bridge_mode_o, MFRC_DRIVE);
        @(posedge clk_i);
        speed_hz_i <= 16'h03E9;
        wfor(MFRC_LS_BRAKE, 5);
        cmp(fault_pin_low_active_n_o, 1'b0);
        @(posedge clk_i);
        speed_hz_i <= 16'h03E8;
        wb(1'b1, 12'h304, 32'h00010000);
        wfor(MFRC_DRIVE, 5);
        for (int md = 0; md < 2; md++) begin
            wb(1'b1, 12'h250, 32'h00004000 | (32'(md) << 17));
            supply_level_i <= 16'h0065;
            wfor(MFRC_TRISTATE, 5);
            cmp(fault_pin_low_active_n_o, 1'b0);
            @(posedge clk_i);
            supply_level_i <= 16'h0064;
            repeat (5) @(posedge clk_i);
            #1;
            cmp(bridge_mode_o, md ? MFRC_DRIVE : MFRC_TRISTATE);
            wb(1'b0, 12'h300, 32'h0);
            cmp(rdv[19], md == 0);
            if (md == 0) wb(1'b1, 12'h304, 32'h00020000);
            wfor(MFRC_DRIVE, 5);
        end
        wb(1'b1, 12'h250, 32'h0);
        supply_level_i <= 16'hFFFF;
        repeat (5) @(posedge clk_i);
        #1;
        cmp(bridge_mode_o, MFRC_DRIVE);
        end_sim();
    end
endmodule
